// ---- shared/rtci_pkg.sv ----
// Constants shared by the register-access slave and its stream buffer.
// Assumes nothing beyond a SystemVerilog compiler.
package rtci_pkg;
   // Own seven-bit bus address; value is arbitrary, set per product
   localparam logic [6:0] SLAVE_ADDR = 7'h32;
   // Bits in one byte, and the count that marks the ninth (ack) slot
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] ACK_SLOT = 4'h9;
   localparam logic [3:0] CNT_RST = 4'h0;
   // Pointer reset value and step
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [7:0] PTR_STEP = 8'h01;
   // Request word layout: read flag, register address, data
   localparam int REQ_W = 17;
   localparam int REQ_RD_BIT = 16;
   localparam int REQ_ADDR_HI = 15;
   localparam int REQ_ADDR_LO = 8;
   localparam int REQ_DATA_HI = 7;
   localparam int REQ_DATA_LO = 0;
   // Depth of the request buffer
   localparam int FIFO_DEPTH = 8;
   // Direction bit value that selects read
   localparam logic DIR_READ = 1'b1;
   // Link engine states
   typedef enum logic [2:0] {
      L_IDLE,
      L_ADDR,
      L_PTR,
      L_WDATA,
      L_TX
   } rtci_lstate_t;
endpackage

// ---- shared/rtci_stream_if.sv ----
// Valid/ready stream carrying request words between modules.
// Assumes producer and consumer share one clock.
`timescale 1ns/1ps
interface rtci_stream_if #(parameter int W = 17);
   logic valid; // Word on offer
   logic ready; // Consumer takes it
   logic [W-1:0] data; // Word
   // Source side
   modport src (output valid, output data, input ready);
   // Sink side
   modport snk (input valid, input data, output ready);
endinterface

// ---- rtl/rtci_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock for both ports and an active-low async reset.
`timescale 1ns/1ps
module rtci_fifo
   import rtci_pkg::*;
#(
   parameter int W = 17,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Fill side
   rtci_stream_if.snk inS,
   // Drain side
   rtci_stream_if.src outS
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH]; // Storage
   logic [AW:0] wrPtr_q; // Write pointer with wrap bit
   logic [AW:0] rdPtr_q; // Read pointer with wrap bit
   wire isEmpty = (wrPtr_q == rdPtr_q);
   wire isFull = (wrPtr_q[AW] != rdPtr_q[AW]) &&
                 (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
   wire doPush = inS.valid && !isFull;
   wire doPop = outS.ready && !isEmpty;

   // Honest flags drive both handshakes
   assign inS.ready = !isFull;
   assign outS.valid = !isEmpty;
   assign outS.data = mem[rdPtr_q[AW-1:0]];

   // Pointer update
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (doPush) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (doPop) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
      end
   end

   // Storage write, no reset needed
   always_ff @(posedge clock) begin
      if (doPush) begin
         mem[wrPtr_q[AW-1:0]] <= inS.data;
      end
   end
endmodule

// ---- rtl/rtci_slave.sv ----
// Two-wire bus slave giving byte access to a register space.
// Assumes the register space answers on the cmd/rsp ports in the
// clock domain, and the bus pins are open drain with pull-ups.
`timescale 1ns/1ps
module rtci_slave
   import rtci_pkg::*;
(
   // System clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Link oversampling clock
   input wire logic linkClk,
   // Bus pins, open drain
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Register space requests
   output logic cmdValid,
   output logic cmdRead,
   output logic [7:0] cmdAddr,
   output logic [7:0] cmdData,
   input wire logic cmdReady,
   // Register space read answers
   input wire logic rspValid,
   input wire logic [7:0] rspData
);
   // ---------------- Link domain ----------------
   logic sclS1_q, sclS2_q; // SCL synchroniser
   logic sdaS1_q, sdaS2_q; // SDA synchroniser
   logic sclP_q, sdaP_q; // Previous synchronised levels
   rtci_lstate_t state_q, state_d; // Link engine state
   logic [3:0] bitCnt_q, bitCnt_d; // Bits seen in this byte
   logic [7:0] rxSh_q, rxSh_d; // Receive shifter
   logic [7:0] txSh_q, txSh_d; // Transmit shifter
   logic [7:0] ptr_q, ptr_d; // Register pointer
   logic nack_q, nack_d; // Master answered with a one
   logic sdaOe_q, sdaOe_d; // Pull SDA low
   logic sclOe_q, sclOe_d; // Stretch SCL low
   logic reqTgl_q, reqTgl_d; // Request toggle to clock domain
   logic [REQ_W-1:0] reqWord_q, reqWord_d; // Held request word
   logic waitRd_q, waitRd_d; // Pending request is a read
   logic ackS1_q, ackS2_q; // Answer toggle synchroniser
   logic pendP_q; // Pending level, last cycle
   logic lineLow_q; // Constant low level for both pins
   logic ackTgl_q; // Answer toggle, clock domain to link domain

   // Bus conditions from synchronised levels
   wire sclRise = sclS2_q && !sclP_q;
   wire sclFall = !sclS2_q && sclP_q;
   wire startSeen = sclS2_q && sclP_q && sdaP_q && !sdaS2_q;
   wire stopSeen = sclS2_q && sclP_q && !sdaP_q && sdaS2_q;
   wire addrHit = (rxSh_q[7:1] == SLAVE_ADDR);
   wire dirRead = (rxSh_q[0] == DIR_READ);
   wire pending = reqTgl_q ^ ackS2_q;
   wire doneSeen = pendP_q && !pending;
   wire byteDone = (bitCnt_q == BYTE_BITS);
   wire ackEnd = (bitCnt_q == ACK_SLOT);
   wire inByte = (bitCnt_q < BYTE_BITS);
   wire [REQ_W-1:0] wrWord = {1'b0, ptr_q, rxSh_q};
   wire [REQ_W-1:0] rdWord = {DIR_READ, ptr_q, 8'h00};
   logic [7:0] rspHold_q; // Read answer, held in clock domain

   // Pin synchronisers and edge history
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         sclS1_q <= 1'b1;
         sclS2_q <= 1'b1;
         sdaS1_q <= 1'b1;
         sdaS2_q <= 1'b1;
         sclP_q <= 1'b1;
         sdaP_q <= 1'b1;
      end else begin
         sclS1_q <= sclIn;
         sclS2_q <= sclS1_q;
         sdaS1_q <= sdaIn;
         sdaS2_q <= sdaS1_q;
         sclP_q <= sclS2_q;
         sdaP_q <= sdaS2_q;
      end
   end

   // Answer toggle back from the clock domain
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         ackS1_q <= 1'b0;
         ackS2_q <= 1'b0;
         pendP_q <= 1'b0;
      end else begin
         ackS1_q <= ackTgl_q;
         ackS2_q <= ackS1_q;
         pendP_q <= pending;
      end
   end

   // Link engine next state
   always_comb begin
      state_d = state_q;
      bitCnt_d = bitCnt_q;
      rxSh_d = rxSh_q;
      txSh_d = txSh_q;
      ptr_d = ptr_q;
      nack_d = nack_q;
      sdaOe_d = sdaOe_q;
      sclOe_d = sclOe_q;
      reqTgl_d = reqTgl_q;
      reqWord_d = reqWord_q;
      waitRd_d = waitRd_q;
      // Stretch let go a cycle after the data bit is set up
      if (!pending && !pendP_q) begin
         sclOe_d = 1'b0;
      end
      // Request finished: present read bit, step pointer
      if (doneSeen) begin
         ptr_d = ptr_q + PTR_STEP;
         if (waitRd_q && state_q == L_TX) begin
            txSh_d = rspHold_q;
            sdaOe_d = !rspHold_q[7];
         end
      end
      if (startSeen) begin
         // New address phase, partial byte dropped
         state_d = L_ADDR;
         bitCnt_d = CNT_RST;
         sdaOe_d = 1'b0;
      end else if (stopSeen) begin
         // Back to idle, bus released
         state_d = L_IDLE;
         bitCnt_d = CNT_RST;
         sdaOe_d = 1'b0;
      end else if (state_q != L_IDLE) begin
         if (sclRise) begin
            // Sample data on the rising edge
            if (inByte) begin
               rxSh_d = {rxSh_q[6:0], sdaS2_q};
               bitCnt_d = bitCnt_q + 4'h1;
            end else if (ackEnd) begin
               nack_d = sdaS2_q;
            end
         end else if (sclFall) begin
            if (byteDone) begin
               // Eighth bit over, ack slot opens
               bitCnt_d = ACK_SLOT;
               unique case (state_q)
                  L_ADDR: begin
                     if (addrHit) begin
                        sdaOe_d = 1'b1;
                     end else begin
                        state_d = L_IDLE;
                     end
                  end
                  L_PTR: begin
                     // Pointer byte loaded and acknowledged
                     ptr_d = rxSh_q;
                     sdaOe_d = 1'b1;
                     state_d = L_WDATA;
                  end
                  L_WDATA: begin
                     // Store at pointer, stretch until buffered
                     reqWord_d = wrWord;
                     reqTgl_d = !reqTgl_q;
                     waitRd_d = 1'b0;
                     sclOe_d = 1'b1;
                     sdaOe_d = 1'b1;
                  end
                  L_TX: begin
                     // Release SDA for the master's answer
                     sdaOe_d = 1'b0;
                  end
                  L_IDLE: begin
                  end
               endcase
            end else if (ackEnd) begin
               // Ack slot over
               bitCnt_d = CNT_RST;
               sdaOe_d = 1'b0;
               if (state_q == L_ADDR) begin
                  state_d = dirRead ? L_TX : L_PTR;
               end
               if ((state_q == L_ADDR && dirRead) ||
                   (state_q == L_TX && !nack_q)) begin
                  // Fetch byte at pointer, stretch meanwhile
                  reqWord_d = rdWord;
                  reqTgl_d = !reqTgl_q;
                  waitRd_d = 1'b1;
                  sclOe_d = 1'b1;
               end
               if (state_q == L_TX && nack_q) begin
                  state_d = L_IDLE;
               end
            end else if (state_q == L_TX && bitCnt_q != CNT_RST) begin
               // Next bit while SCL is low
               txSh_d = {txSh_q[6:0], 1'b0};
               sdaOe_d = !txSh_q[6];
            end
         end
      end
   end

   // Link engine registers
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= L_IDLE;
         bitCnt_q <= CNT_RST;
         rxSh_q <= 8'h00;
         txSh_q <= 8'h00;
         ptr_q <= PTR_RST;
         nack_q <= 1'b0;
         sdaOe_q <= 1'b0;
         sclOe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         bitCnt_q <= bitCnt_d;
         rxSh_q <= rxSh_d;
         txSh_q <= txSh_d;
         ptr_q <= ptr_d;
         nack_q <= nack_d;
         sdaOe_q <= sdaOe_d;
         sclOe_q <= sclOe_d;
      end
   end

   // Request handshake registers
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         reqTgl_q <= 1'b0;
         reqWord_q <= '0;
         waitRd_q <= 1'b0;
         lineLow_q <= 1'b0;
      end else begin
         reqTgl_q <= reqTgl_d;
         reqWord_q <= reqWord_d;
         waitRd_q <= waitRd_d;
         lineLow_q <= 1'b0;
      end
   end

   // Pins only ever pulled low
   assign sdaOut = lineLow_q;
   assign sclOut = lineLow_q;
   assign sdaOe = sdaOe_q;
   assign sclOe = sclOe_q;

   // ---------------- Clock domain ----------------
   logic reqS1_q, reqS2_q; // Request toggle synchroniser
   logic reqSeen_q; // Last request toggle taken
   logic rdWait_q; // A read is out at the register space
   logic cmdValid_q, cmdRead_q; // Command registers
   logic [7:0] cmdAddr_q, cmdData_q;
   rtci_stream_if #(.W(REQ_W)) fillIf ();
   rtci_stream_if #(.W(REQ_W)) drainIf ();

   // New request offered to the buffer; word is stable meanwhile
   wire newReq = reqS2_q ^ reqSeen_q;
   wire pushed = newReq && fillIf.ready;
   wire wrAck = pushed && !reqWord_q[REQ_RD_BIT];
   wire rdAck = rdWait_q && rspValid;
   wire cmdFree = !cmdValid_q || cmdReady;
   wire popNow = drainIf.valid && cmdFree && !rdWait_q;
   wire popRead = drainIf.data[REQ_RD_BIT];
   assign fillIf.valid = newReq;
   assign fillIf.data = reqWord_q;
   assign drainIf.ready = popNow;

   // Request buffer; full stalls the toggle and so stretches SCL
   rtci_fifo #(.W(REQ_W), .DEPTH(FIFO_DEPTH)) reqFifo (
      .clock(clock),
      .rst_n(rst_n),
      .inS(fillIf),
      .outS(drainIf)
   );

   // Toggle synchroniser and handshake state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reqS1_q <= 1'b0;
         reqS2_q <= 1'b0;
         reqSeen_q <= 1'b0;
         ackTgl_q <= 1'b0;
      end else begin
         reqS1_q <= reqTgl_q;
         reqS2_q <= reqS1_q;
         reqSeen_q <= reqSeen_q ^ pushed;
         ackTgl_q <= ackTgl_q ^ (wrAck || rdAck);
      end
   end

   // Read tracking and answer capture
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdWait_q <= 1'b0;
         rspHold_q <= 8'h00;
      end else begin
         if (popNow && popRead) begin
            rdWait_q <= 1'b1;
         end else if (rdAck) begin
            rdWait_q <= 1'b0;
         end
         if (rdAck) begin
            rspHold_q <= rspData;
         end
      end
   end

   // Command output registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cmdValid_q <= 1'b0;
         cmdRead_q <= 1'b0;
         cmdAddr_q <= 8'h00;
         cmdData_q <= 8'h00;
      end else if (popNow) begin
         cmdValid_q <= 1'b1;
         cmdRead_q <= popRead;
         cmdAddr_q <= drainIf.data[REQ_ADDR_HI:REQ_ADDR_LO];
         cmdData_q <= drainIf.data[REQ_DATA_HI:REQ_DATA_LO];
      end else if (cmdReady) begin
         cmdValid_q <= 1'b0;
      end
   end

   assign cmdValid = cmdValid_q;
   assign cmdRead = cmdRead_q;
   assign cmdAddr = cmdAddr_q;
   assign cmdData = cmdData_q;
endmodule

// ---- test/rtci_slave_assertions.sv ----
// Port checks for the two-wire register slave.
// Assumes it is bound to every rtci_slave instance.
`timescale 1ns/1ps
module rtci_slave_assertions (
   // Clocks and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic linkClk,
   // Bus pins
   input wire logic sclIn,
   input wire logic sclOut,
   input wire logic sclOe,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   // Register space side
   input wire logic cmdValid,
   input wire logic cmdRead,
   input wire logic [7:0] cmdAddr,
   input wire logic [7:0] cmdData,
   input wire logic cmdReady,
   input wire logic rspValid,
   input wire logic [7:0] rspData
);
   // Read handed over, then quiet until answered
   sequence s_rdGo;
      cmdValid && cmdReady && cmdRead;
   endsequence
   sequence s_rdWait;
      !cmdValid throughout (##[0:40] rspValid);
   endsequence
   AST_PULL_ONLY: assert property (
      @(posedge linkClk) disable iff (!rst_n) !sdaOut && !sclOut)
      else $error("pin driven high");
   AST_SDA_LOW: assert property (
      @(posedge linkClk) disable iff (!rst_n)
      $changed(sdaOe) |-> !sclIn && !$past(sclIn))
      else $error("data moved while clock high");
   AST_STRETCH_LOW: assert property (
      @(posedge linkClk) disable iff (!rst_n) $rose(sclOe) |-> !sclIn)
      else $error("stretch began while clock high");
   AST_LINK_RST: assert property (
      @(posedge linkClk) disable iff (!rst_n)
      $rose(rst_n) |-> !sdaOe && !sclOe)
      else $error("pins held after reset");
   AST_CMD_HOLD: assert property (
      @(posedge clock) disable iff (!rst_n) cmdValid && !cmdReady |=>
      cmdValid && $stable({cmdRead, cmdAddr, cmdData}))
      else $error("command dropped or changed");
   AST_RD_ZERO: assert property (
      @(posedge clock) disable iff (!rst_n)
      cmdValid && cmdRead |-> cmdData == 8'h00)
      else $error("read carries data");
   AST_RD_WAIT: assert property (
      @(posedge clock) disable iff (!rst_n) s_rdGo |=> s_rdWait)
      else $error("command issued while read waits");
   AST_CLK_RST: assert property (
      @(posedge clock) disable iff (!rst_n) $rose(rst_n) |-> !cmdValid)
      else $error("command after reset");
endmodule
bind rtci_slave rtci_slave_assertions chk_u (.clock(clock), .rst_n(rst_n),
   .linkClk(linkClk), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
   .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .cmdValid(cmdValid),
   .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdData(cmdData),
   .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData));

// ---- test/rtci_i2c_master.sv ----
// Bus master model working the pins through pull-low enables.
// Assumes the bench resolves the wires with pull-ups.
`timescale 1ns/1ps
module rtci_i2c_master (
   // Resolved wire levels
   input wire logic sclWire,
   input wire logic sdaWire,
   // Pull-low enables
   output logic sclDrv,
   output logic sdaDrv
);
   localparam int HALF = 100; // Half bit, short transfers
   initial begin
      sclDrv = 1'b0;
      sdaDrv = 1'b0;
   end
   // Release clock, wait out a stretch, hold high
   task automatic sclHigh();
      int n;
      n = 0;
      #(HALF / 4); // Data setup before the clock rises
      sclDrv = 1'b0;
      #1;
      while (sclWire !== 1'b1 && n < 20000) begin
         #10;
         n++;
      end
      #HALF;
   endtask
   // Pull clock low and hold
   task automatic sclLow();
      sclDrv = 1'b1;
      #HALF;
   endtask
   // Data set while clock low
   task automatic bitOut(input logic b);
      sdaDrv = !b;
      sclHigh();
      sclLow();
   endtask
   task automatic busStart();
      sdaDrv = 1'b0;
      sclHigh();
      sdaDrv = 1'b1;
      #HALF;
      sclLow();
   endtask
   task automatic busStop();
      sdaDrv = 1'b1;
      sclHigh();
      sdaDrv = 1'b0;
      #HALF;
   endtask
   // Eight bits, then the slave's ack
   task automatic wrByte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) bitOut(d[i]);
      sdaDrv = 1'b0;
      sclHigh();
      ack = sdaWire;
      sclLow();
   endtask
   // Eight bits in, then our ack or final nack
   task automatic rdByte(input logic last, output logic [7:0] d);
      sdaDrv = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         sclHigh();
         d[i] = sdaWire;
         sclLow();
      end
      bitOut(last);
   endtask
endmodule

// ---- test/i2c_slave_register_access_tb.sv ----
// Self-checking bench for the two-wire register slave.
// Assumes the master model and checker bind are compiled first.
`timescale 1ns/1ps
module i2c_slave_register_access_tb
   import rtci_pkg::*;
();
   logic clock, linkClk, rst_n; // Clocks and reset
   logic cmdReady, rspValid; // Register space answers
   logic [7:0] rspData, cmdAddr, cmdData, rdAddr, ptrM, d;
   logic sclOut, sclOe, sdaOut, sdaOe, cmdValid, cmdRead;
   logic mScl, mSda, stall, rdPend, a; // Master drive, bench state
   logic [7:0] regMem [256]; // Register space
   logic [7:0] modelMem [256]; // Expected contents
   logic [15:0] expQ [$]; // Expected write commands
   logic [15:0] lfsrQ, expW;
   int error_cnt, cmp_count;
   wire logic sclW;
   wire logic sdaW;
   // Open-drain wires with pull-ups
   assign sclW = ~((sclOe & ~sclOut) | mScl);
   assign sdaW = ~((sdaOe & ~sdaOut) | mSda);
   rtci_slave dut_u (.clock(clock), .rst_n(rst_n), .linkClk(linkClk),
      .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaW),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .cmdValid(cmdValid),
      .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdData(cmdData),
      .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData));
   rtci_i2c_master mst_u (.sclWire(sclW), .sdaWire(sdaW),
      .sclDrv(mScl), .sdaDrv(mSda));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      linkClk = 1'b0;
      #3;
      forever #6 linkClk = ~linkClk;
   end
   function automatic logic [15:0] lfsrNext(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Count and report one comparison
   task automatic tally(input logic bad, input logic [15:0] g, e);
      cmp_count++;
      if (bad) begin
         error_cnt++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmpAck(input logic g, e);
      tally(g !== e, 16'(g), 16'(e));
   endtask
   task automatic cmpByte(input logic [7:0] g, e);
      tally(g !== e, 16'(g), 16'(e));
   endtask
   task automatic cmpCmd(input logic [15:0] g, e);
      tally(g !== e, g, e);
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Register space: random readiness, read answered a cycle later
   always @(posedge clock) begin
      if (cmdValid === 1'b1 && cmdReady === 1'b1) begin
         if (cmdRead === 1'b1) begin
            rdPend = 1'b1;
            rdAddr = cmdAddr;
         end else begin
            expW = expQ.size() ? expQ.pop_front() : 16'hXXXX;
            cmpCmd({cmdAddr, cmdData}, expW);
            regMem[cmdAddr] = cmdData;
         end
      end
      #1;
      lfsrQ = lfsrNext(lfsrQ);
      cmdReady = !stall && lfsrQ[0];
      rspValid = rdPend;
      rspData = rdPend ? regMem[rdAddr] : lfsrQ[15:8];
      rdPend = 1'b0;
   end
   // Address phase after a start
   task automatic txStart(input logic rd);
      mst_u.busStart();
      mst_u.wrByte({SLAVE_ADDR, rd}, a);
      cmpAck(a, 1'b0);
   endtask
   task automatic setPtr(input logic [7:0] p);
      txStart(1'b0);
      mst_u.wrByte(p, a);
      cmpAck(a, 1'b0);
      ptrM = p;
   endtask
   // Pointer then n random data bytes
   task automatic wrTxn(input logic [7:0] p, input int n);
      setPtr(p);
      repeat (n) begin
         lfsrQ = lfsrNext(lfsrQ);
         d = lfsrQ[7:0];
         expQ.push_back({ptrM, d});
         modelMem[ptrM] = d;
         mst_u.wrByte(d, a);
         cmpAck(a, 1'b0);
         ptrM++;
      end
      mst_u.busStop();
   endtask
   // Read n bytes, with or without a pointer write first
   task automatic rdTxn(input logic fresh, input logic [7:0] p, int n);
      if (fresh) setPtr(p);
      txStart(1'b1);
      for (int i = 0; i < n; i++) begin
         mst_u.rdByte(i == n - 1, d);
         cmpByte(d, modelMem[ptrM]);
         ptrM++;
      end
      mst_u.busStop();
      cmpAck(sdaOe, 1'b0);
   endtask
   initial begin
      #2000000;
      error_cnt++;
      give_verdict();
   end
   initial begin
      rst_n = 1'b0;
      cmdReady = 1'b0;
      rspValid = 1'b0;
      rspData = 8'h00;
      {stall, rdPend, ptrM, rdAddr} = '0;
      lfsrQ = 16'h5733;
      error_cnt = 0;
      cmp_count = 0;
      for (int i = 0; i < 256; i++) begin
         regMem[i] = 8'(i * 7 + 3);
         modelMem[i] = 8'(i * 7 + 3);
      end
      repeat (4) @(posedge clock);
      #1 rst_n = 1'b1;
      repeat (2) @(posedge clock);
      // Burst over the pointer wrap while the register space stalls
      stall = 1'b1;
      fork
         begin
            repeat (800) @(posedge clock);
            cmpAck(cmdValid, 1'b1);
            #1 stall = 1'b0;
         end
      join_none
      wrTxn(8'hFE, 10);
      rdTxn(1'b1, 8'hFE, 3);
      rdTxn(1'b0, 8'h00, 2);
      // Foreign address is ignored
      mst_u.busStart();
      mst_u.wrByte({SLAVE_ADDR ^ 7'h01, 1'b0}, a);
      cmpAck(a, 1'b1);
      mst_u.wrByte(8'h55, a);
      cmpAck(a, 1'b1);
      mst_u.busStop();
      // Data byte cut short by a stop, then a clean write
      setPtr(8'h40);
      for (int i = 0; i < 4; i++) mst_u.bitOut(i[0]);
      mst_u.busStop();
      wrTxn(8'h80, 2);
      rdTxn(1'b0, 8'h00, 1);
      for (int i = 0; i < 200 && expQ.size() != 0; i++) @(posedge clock);
      cmpByte(8'(expQ.size()), 8'h00);
      give_verdict();
   end
endmodule
